// file: shared/rxbb_pkg.sv
// Constants, register map and types of the receiver baseband configuration block.
package rxbb_pkg;
    localparam int CLK_PERIOD_NS = 25;
    // Register offsets.
    localparam logic [7:0] OFS_DEMODULATOR_CONFIG = 8'h00;
    localparam logic [7:0] OFS_GAIN_LOOP_CONFIG = 8'h01;
    localparam logic [7:0] OFS_IF_AND_FILTER_SELECT = 8'h02;
    localparam logic [7:0] OFS_GAIN_ATTACK_LEVEL = 8'h03;
    localparam logic [7:0] OFS_SIGNAL_STRENGTH_VALUE = 8'h10;
    // Field positions.
    localparam int TCTRL_LSB = 0;
    localparam int FSK_LSB = 3;
    localparam int MODE_LSB = 0;
    localparam int MODE_EN_BIT = 1;
    localparam int REL_LSB = 2;
    localparam int TRIM_LSB = 6;
    localparam int IFSEL_BIT = 0;
    localparam int CHF_LSB = 1;
    localparam int MOD_BIT = 4;
    // Reset values.
    localparam logic [7:0] DEMODULATOR_CONFIG_RST = 8'h04;
    localparam logic [7:0] GAIN_RST = 8'h26;
    localparam logic [7:0] IFCHF_RST = 8'h00;
    localparam logic [7:0] ATTACK_RST = 8'hC0;
    localparam logic [3:0] REL_PAD = 4'h0;
    // Gain correction applied while the front end sits in low gain (0.5dB steps).
    localparam logic [7:0] GAIN_STEP = 8'h28;
    localparam logic [7:0] STRENGTH_MAX = 8'hFF;
    // Peak detector decay timing.
    localparam int STEP_BASE_NS = 1670;
    localparam logic [23:0] STEP_BASE_CYC = 24'(STEP_BASE_NS / CLK_PERIOD_NS);
    localparam int PRESET_ASK_NS = 428000;
    localparam int PRESET_ASK_CYC = PRESET_ASK_NS / CLK_PERIOD_NS;
    localparam int PRESET_FSK_NS = 53000;
    localparam logic [23:0] PRESET_FSK_CYC = 24'(PRESET_FSK_NS / CLK_PERIOD_NS);
    // Serial strength frame timing.
    localparam int BIT_NS = 20000;
    localparam logic [9:0] BIT_CYC = 10'(BIT_NS / CLK_PERIOD_NS);
    localparam logic [4:0] FRAME_LAST = 5'd19;
    localparam logic [9:0] IDLE_ONES = 10'h3FF;
    localparam logic [19:0] FRAME_IDLE = 20'hFFFFF;
    // Serial bus slave.
    localparam logic [6:0] DEV_ADDR = 7'h2A; // Arbitrary value.
    localparam logic [3:0] BYTE_BITS = 4'h8;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_ACK_A = 3'h3,
        ST_WR = 3'h2,
        ST_ACK_W = 3'h6,
        ST_RD = 3'h7,
        ST_ACK_R = 3'h5
    } rxbb_state_t;
endpackage

// file: shared/rxbb_level_if.sv
// Carries the held strength level from the peak detector to its readers.
`timescale 1ns/100ps
`default_nettype none
interface rxbb_level_if;
    logic [7:0] level;
    modport pd (output level);
    modport ser (input level);
endinterface
`default_nettype wire

// file: rtl/rxbb_peak_hold.sv
// Peak detector with stepwise decay on the corrected strength samples.
`timescale 1ns/100ps
`default_nettype none
module rxbb_peak_hold (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [7:0] sample_in,
    input wire logic [23:0] decay_cyc_in,
    rxbb_level_if.pd lvl
);
    logic [7:0] peak_reg;
    logic [23:0] tick_reg;

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            peak_reg <= 8'h00;
            tick_reg <= 24'h000000;
        end else if (sample_in >= peak_reg) begin
            peak_reg <= sample_in;
            tick_reg <= 24'h000000;
        end else if (tick_reg >= decay_cyc_in - 24'h000001) begin
            peak_reg <= peak_reg - 8'h01;
            tick_reg <= 24'h000000;
        end else begin
            tick_reg <= tick_reg + 24'h000001;
        end
    end

    assign lvl.level = peak_reg;

    peak_track_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        sample_in >= peak_reg |=> peak_reg == $past(sample_in))
        else $error("peak did not follow a larger sample");
    decay_step_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        ($past(sample_in) < $past(peak_reg)) && (peak_reg != $past(peak_reg)) |->
        (peak_reg == $past(peak_reg) - 8'h01) &&
        ($past(tick_reg) >= $past(decay_cyc_in) - 24'h000001))
        else $error("peak decayed off its period");
    decay_seen_c: cover property (@(posedge clk_in) disable iff (!rst_b_in)
        sample_in < peak_reg ##1 peak_reg < $past(peak_reg));
endmodule
`default_nettype wire

// file: rtl/rxbb_strength_tx.sv
// Serial sender of the strength frame on the strength pin.
`timescale 1ns/100ps
`default_nettype none
module rxbb_strength_tx (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic enable_in,
    rxbb_level_if.ser lvl,
    output logic tx_out
);
    logic [19:0] frame_reg;
    logic [4:0] bit_reg;
    logic [9:0] div_reg;
    logic load;

    assign load = enable_in && (div_reg == rxbb_pkg::BIT_CYC - 10'h001)
        && (bit_reg == rxbb_pkg::FRAME_LAST);

    always_ff @(posedge clk_in) begin
        if (!rst_b_in || !enable_in) begin
            // Parked so that the first frame starts one cycle after enabling.
            frame_reg <= rxbb_pkg::FRAME_IDLE;
            bit_reg <= rxbb_pkg::FRAME_LAST;
            div_reg <= rxbb_pkg::BIT_CYC - 10'h001;
        end else if (div_reg == rxbb_pkg::BIT_CYC - 10'h001) begin
            div_reg <= 10'h000;
            if (load) begin
                bit_reg <= 5'h00;
                frame_reg <= {1'b0, lvl.level, ^lvl.level, rxbb_pkg::IDLE_ONES};
            end else begin
                bit_reg <= bit_reg + 5'h01;
                frame_reg <= {frame_reg[18:0], 1'b1};
            end
        end else begin
            div_reg <= div_reg + 10'h001;
        end
    end

    assign tx_out = frame_reg[19];

    frame_load_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        load ##1 enable_in |->
        frame_reg == {1'b0, $past(lvl.level), ^$past(lvl.level), rxbb_pkg::IDLE_ONES})
        else $error("frame content wrong");
    bit_edge_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        enable_in && $past(enable_in) && $changed(tx_out) |-> div_reg == 10'h000)
        else $error("pin changed inside a bit period");
    frame_sent_c: cover property (@(posedge clk_in) disable iff (!rst_b_in)
        load ##1 enable_in);
endmodule
`default_nettype wire

// file: rtl/rxbb_top.sv
// Receiver baseband configuration registers, gain loop and strength reporting.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - IF select bit picks 400kHz IF when 0, 200kHz IF when 1.
// - Filter code 0..4 sets bandwidth 340,120,52,24,12kHz, halved at 200kHz IF.
// - Modulation select bit gives ASK when 0 and FSK when 1.
// - FSK demodulator_config setting acts only in FSK mode; 28 deviation options overall.
// - Reset defaults give 400kHz IF, filter 0, FSK setting 0, 80kHz deviation.
// - Gain drops high to low when raw strength exceeds attack threshold.
// - Gain returns low to high when raw strength falls below release threshold.
// - Gain mode codes 0,1 disable switching; 2,3 enable; 2 after reset.
// - Strength register reads the peak-held gain-corrected value, 0.5dB per bit, uncalibrated.
// - Strength is a log envelope followed by a decaying peak detector.
// - Decay step is 1.67us times 2^N, N from summed codes minus one.
// - Preset mode fixes decay at 428us for ASK, 53us for FSK.
// - Preset mode sends strength serially on the strength pin at 50kbps.
// - Frame is 0, eight value bits MSB first, parity, ten ones.
// - Parity bit is the XOR of the eight value bits.
module rxbb_top #(
    parameter int PRESET_ASK_DECAY_CYC = rxbb_pkg::PRESET_ASK_CYC
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic [7:0] raw_strength_in,
    input wire logic preset_mode_in,
    output logic if_select_out,
    output logic [2:0] chan_filter_select_out,
    output logic modulation_select_out,
    output logic [2:0] demodulator_config_time_ctrl_out,
    output logic [2:0] fsk_demodulator_config_setting_out,
    output logic gain_low_out,
    output logic strength_pin_out
);
    rxbb_pkg::rxbb_state_t state_reg;
    logic scl_q_reg;
    logic sda_q_reg;
    logic [7:0] shift_reg;
    logic [7:0] tx_reg;
    logic [3:0] bit_reg;
    logic rw_reg;
    logic first_reg;
    logic nack_reg;
    logic [7:0] ptr_reg;
    logic wr_stb_reg;
    logic [7:0] wr_addr_reg;
    logic [7:0] wr_data_reg;
    logic sda_oe_reg;
    logic sda_drv_reg;
    logic [7:0] demodulator_config_cfg_reg;
    logic [7:0] gain_cfg_reg;
    logic [7:0] if_chf_reg;
    logic [7:0] attack_reg;
    logic gain_low_reg;
    logic [23:0] decay_cyc_reg;
    logic scl_rise;
    logic scl_fall;
    logic start_evt;
    logic stop_evt;
    logic [7:0] rd_data;
    logic [8:0] corr_sum;
    logic [7:0] corrected;
    logic [7:0] release_level;
    logic gain_enable;
    logic fsk_mode;
    logic [4:0] decay_sum;
    logic [4:0] decay_n;

    rxbb_level_if lvl_if ();

    assign scl_rise = scl_in && !scl_q_reg;
    assign scl_fall = !scl_in && scl_q_reg;
    assign start_evt = scl_in && scl_q_reg && sda_q_reg && !sda_in;
    assign stop_evt = scl_in && scl_q_reg && !sda_q_reg && sda_in;

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            scl_q_reg <= 1'b1;
            sda_q_reg <= 1'b1;
        end else begin
            scl_q_reg <= scl_in;
            sda_q_reg <= sda_in;
        end
    end

    always_comb begin
        case (ptr_reg)
            rxbb_pkg::OFS_DEMODULATOR_CONFIG: rd_data = demodulator_config_cfg_reg;
            rxbb_pkg::OFS_GAIN_LOOP_CONFIG: rd_data = gain_cfg_reg;
            rxbb_pkg::OFS_IF_AND_FILTER_SELECT: rd_data = if_chf_reg;
            rxbb_pkg::OFS_GAIN_ATTACK_LEVEL: rd_data = attack_reg;
            rxbb_pkg::OFS_SIGNAL_STRENGTH_VALUE: rd_data = lvl_if.level;
            default: rd_data = 8'h00;
        endcase
    end

    // Serial slave: first written byte is the register pointer, then data with
    // auto-increment. Reads start from the pointer and also auto-increment.
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            state_reg <= rxbb_pkg::ST_IDLE;
            shift_reg <= 8'h00;
            tx_reg <= 8'h00;
            bit_reg <= 4'h0;
            rw_reg <= 1'b0;
            first_reg <= 1'b1;
            nack_reg <= 1'b0;
            ptr_reg <= 8'h00;
            wr_stb_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            wr_data_reg <= 8'h00;
            sda_oe_reg <= 1'b0;
        end else begin
            wr_stb_reg <= 1'b0;
            if (start_evt) begin
                state_reg <= rxbb_pkg::ST_ADDR;
                bit_reg <= 4'h0;
                first_reg <= 1'b1;
                sda_oe_reg <= 1'b0;
            end else if (stop_evt) begin
                state_reg <= rxbb_pkg::ST_IDLE;
                sda_oe_reg <= 1'b0;
            end else begin
                case (state_reg)
                    rxbb_pkg::ST_ADDR, rxbb_pkg::ST_WR: begin
                        if (scl_rise) begin
                            shift_reg <= {shift_reg[6:0], sda_in};
                            bit_reg <= bit_reg + 4'h1;
                        end else if (scl_fall && bit_reg == rxbb_pkg::BYTE_BITS) begin
                            bit_reg <= 4'h0;
                            if (state_reg == rxbb_pkg::ST_ADDR) begin
                                if (shift_reg[7:1] == rxbb_pkg::DEV_ADDR) begin
                                    state_reg <= rxbb_pkg::ST_ACK_A;
                                    rw_reg <= shift_reg[0];
                                    sda_oe_reg <= 1'b1;
                                end else begin
                                    state_reg <= rxbb_pkg::ST_IDLE;
                                end
                            end else begin
                                state_reg <= rxbb_pkg::ST_ACK_W;
                                sda_oe_reg <= 1'b1;
                                if (first_reg) begin
                                    ptr_reg <= shift_reg;
                                    first_reg <= 1'b0;
                                end else begin
                                    wr_stb_reg <= 1'b1;
                                    wr_addr_reg <= ptr_reg;
                                    wr_data_reg <= shift_reg;
                                    ptr_reg <= ptr_reg + 8'h01;
                                end
                            end
                        end
                    end
                    rxbb_pkg::ST_ACK_A: begin
                        if (scl_fall) begin
                            if (rw_reg) begin
                                state_reg <= rxbb_pkg::ST_RD;
                                tx_reg <= rd_data;
                                sda_oe_reg <= !rd_data[7];
                                bit_reg <= 4'h1;
                            end else begin
                                state_reg <= rxbb_pkg::ST_WR;
                                sda_oe_reg <= 1'b0;
                            end
                        end
                    end
                    rxbb_pkg::ST_ACK_W: begin
                        if (scl_fall) begin
                            state_reg <= rxbb_pkg::ST_WR;
                            sda_oe_reg <= 1'b0;
                        end
                    end
                    rxbb_pkg::ST_RD: begin
                        if (scl_fall) begin
                            if (bit_reg == rxbb_pkg::BYTE_BITS) begin
                                state_reg <= rxbb_pkg::ST_ACK_R;
                                sda_oe_reg <= 1'b0;
                                ptr_reg <= ptr_reg + 8'h01;
                            end else begin
                                tx_reg <= {tx_reg[6:0], 1'b0};
                                sda_oe_reg <= !tx_reg[6];
                                bit_reg <= bit_reg + 4'h1;
                            end
                        end
                    end
                    rxbb_pkg::ST_ACK_R: begin
                        if (scl_rise) begin
                            nack_reg <= sda_in;
                        end else if (scl_fall) begin
                            if (nack_reg) begin
                                state_reg <= rxbb_pkg::ST_IDLE;
                            end else begin
                                state_reg <= rxbb_pkg::ST_RD;
                                tx_reg <= rd_data;
                                sda_oe_reg <= !rd_data[7];
                                bit_reg <= 4'h1;
                            end
                        end
                    end
                    default: begin
                        state_reg <= rxbb_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end

    // The data pin is open drain: it only ever pulls low.
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            sda_drv_reg <= 1'b0;
        end else begin
            sda_drv_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            demodulator_config_cfg_reg <= rxbb_pkg::DEMODULATOR_CONFIG_RST;
            gain_cfg_reg <= rxbb_pkg::GAIN_RST;
            if_chf_reg <= rxbb_pkg::IFCHF_RST;
            attack_reg <= rxbb_pkg::ATTACK_RST;
        end else if (wr_stb_reg) begin
            case (wr_addr_reg)
                rxbb_pkg::OFS_DEMODULATOR_CONFIG: demodulator_config_cfg_reg <= wr_data_reg;
                rxbb_pkg::OFS_GAIN_LOOP_CONFIG: gain_cfg_reg <= wr_data_reg;
                rxbb_pkg::OFS_IF_AND_FILTER_SELECT: if_chf_reg <= wr_data_reg;
                rxbb_pkg::OFS_GAIN_ATTACK_LEVEL: attack_reg <= wr_data_reg;
                default: attack_reg <= attack_reg;
            endcase
        end
    end

    assign fsk_mode = if_chf_reg[rxbb_pkg::MOD_BIT];
    assign gain_enable = gain_cfg_reg[rxbb_pkg::MODE_LSB + rxbb_pkg::MODE_EN_BIT];
    assign release_level = {gain_cfg_reg[rxbb_pkg::REL_LSB +: 4], rxbb_pkg::REL_PAD};

    // Configuration driven to the analog front end and demodulator.
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            if_select_out <= 1'b0;
            chan_filter_select_out <= 3'h0;
            modulation_select_out <= 1'b0;
            demodulator_config_time_ctrl_out <= 3'h0;
            fsk_demodulator_config_setting_out <= 3'h0;
        end else begin
            if_select_out <= if_chf_reg[rxbb_pkg::IFSEL_BIT];
            chan_filter_select_out <= if_chf_reg[rxbb_pkg::CHF_LSB +: 3];
            modulation_select_out <= fsk_mode;
            demodulator_config_time_ctrl_out <= demodulator_config_cfg_reg[rxbb_pkg::TCTRL_LSB +: 3];
            fsk_demodulator_config_setting_out <= fsk_mode ? demodulator_config_cfg_reg[rxbb_pkg::FSK_LSB +: 3] : 3'h0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in || !gain_enable) begin
            gain_low_reg <= 1'b0;
        end else if (!gain_low_reg && raw_strength_in > attack_reg) begin
            gain_low_reg <= 1'b1;
        end else if (gain_low_reg && raw_strength_in < release_level) begin
            gain_low_reg <= 1'b0;
        end
    end

    assign gain_low_out = gain_low_reg;

    assign corr_sum = {1'b0, raw_strength_in} + {1'b0, rxbb_pkg::GAIN_STEP};
    assign corrected = !gain_low_reg ? raw_strength_in :
        (corr_sum[8] ? rxbb_pkg::STRENGTH_MAX : corr_sum[7:0]);

    // Sum is wide enough for the largest codes, so the shift never overflows 24 bits.
    assign decay_sum = {4'h0, if_chf_reg[rxbb_pkg::IFSEL_BIT]}
        + {2'h0, if_chf_reg[rxbb_pkg::CHF_LSB +: 3]}
        + {2'h0, demodulator_config_cfg_reg[rxbb_pkg::TCTRL_LSB +: 3]}
        + {3'h0, gain_cfg_reg[rxbb_pkg::TRIM_LSB +: 2]};
    assign decay_n = (decay_sum == 5'h00) ? 5'h00 : decay_sum - 5'h01;

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            decay_cyc_reg <= rxbb_pkg::STEP_BASE_CYC;
        end else if (preset_mode_in) begin
            decay_cyc_reg <= fsk_mode ? rxbb_pkg::PRESET_FSK_CYC : 24'(PRESET_ASK_DECAY_CYC);
        end else begin
            decay_cyc_reg <= rxbb_pkg::STEP_BASE_CYC << decay_n;
        end
    end

    rxbb_peak_hold u_peak (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .sample_in(corrected),
        .decay_cyc_in(decay_cyc_reg),
        .lvl(lvl_if.pd)
    );

    rxbb_strength_tx u_tx (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .enable_in(preset_mode_in),
        .lvl(lvl_if.ser),
        .tx_out(strength_pin_out)
    );

    assign sda_out = sda_drv_reg;
    assign sda_oe_out = sda_oe_reg;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);

    gain_attack_a: assert property (
        gain_enable && !gain_low_reg && raw_strength_in > attack_reg ##1 gain_enable
        |-> gain_low_out)
        else $error("gain did not drop above attack level");
    gain_release_a: assert property (
        gain_enable && gain_low_reg && raw_strength_in < release_level ##1 gain_enable
        |-> !gain_low_out)
        else $error("gain did not return below release level");
    gain_off_a: assert property (!gain_enable |=> !gain_low_out)
        else $error("gain switched while disabled");
    fsk_gate_a: assert property (!fsk_mode |=> fsk_demodulator_config_setting_out == 3'h0)
        else $error("FSK setting leaked in ASK mode");
    preset_decay_a: assert property (
        preset_mode_in && fsk_mode |=> decay_cyc_reg == rxbb_pkg::PRESET_FSK_CYC)
        else $error("preset FSK decay wrong");
    pin_idle_a: assert property (!preset_mode_in |=> strength_pin_out)
        else $error("strength pin active outside preset mode");
    ack_drive_a: assert property (
        state_reg == rxbb_pkg::ST_ACK_A || state_reg == rxbb_pkg::ST_ACK_W |-> sda_oe_out)
        else $error("acknowledge not driven");
    gain_drop_c: cover property (!gain_low_reg ##1 gain_low_reg);
    reg_write_c: cover property (wr_stb_reg);
endmodule
`default_nettype wire

// file: sim/rxbb_pin_sampler.sv
// Behavioural controller that decodes serial strength frames from the pin.
`timescale 1ns/100ps
`default_nettype none
module rxbb_pin_sampler #(
    parameter int BITC = 800
) (
    input wire logic clk_in,
    input wire logic pin_in,
    output logic [7:0] value_out,
    output int good_out,
    output int bad_out
);
    int ones;
    logic [8:0] sh;
    initial begin
        value_out = 8'h00;
        good_out = 0;
        bad_out = 0;
        ones = 0;
        forever begin
            // Sampling on the falling edge keeps clear of the edge that launches each bit.
            @(negedge clk_in);
            if (pin_in === 1'b1) begin
                ones++;
            end else if (pin_in === 1'b0 && ones >= 19 * BITC / 2) begin
                repeat (BITC / 2) @(negedge clk_in);
                for (int i = 8; i >= 0; i--) begin
                    repeat (BITC) @(negedge clk_in);
                    sh[i] = pin_in;
                end
                // parity gate. An unknown bit lands in the bad count.
                if (^sh === 1'b0) begin
                    value_out = sh[8:1];
                    good_out++;
                end else begin
                    bad_out++;
                end
                ones = 0;
            end else begin
                ones = 0;
            end
        end
    end
endmodule
`default_nettype wire

// file: sim/tb_rx_baseband_config_signal_strength_value.sv
// Testbench for the receiver baseband configuration and strength block.
`timescale 1ns/100ps
`default_nettype none
module tb_rx_baseband_config_signal_strength_value;
    logic clk, rst_b, scl, tb_sda, preset, gl, pin, ifs, mods, oe, mg;
    logic [7:0] raw, rd, smp_v;
    logic [2:0] chf, tc, fsk;
    int num_errors, comparisons, good, bad, n;
    logic [7:0] gr [4] = '{8'hC0, 8'hC1, 8'h90, 8'h8F};
    wire logic sda_w = tb_sda & ~oe;
    rxbb_top #(.PRESET_ASK_DECAY_CYC(200)) dut (.clk_in(clk), .rst_b_in(rst_b), .scl_in(scl),
        .sda_in(sda_w), .sda_out(), .sda_oe_out(oe), .raw_strength_in(raw),
        .preset_mode_in(preset), .if_select_out(ifs), .chan_filter_select_out(chf),
        .modulation_select_out(mods), .demodulator_config_time_ctrl_out(tc), .fsk_demodulator_config_setting_out(fsk),
        .gain_low_out(gl), .strength_pin_out(pin));
    rxbb_pin_sampler #(.BITC(int'(rxbb_pkg::BIT_CYC))) smp (.clk_in(clk), .pin_in(pin),
        .value_out(smp_v), .good_out(good), .bad_out(bad));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic t(input int k);
        repeat (k) @(posedge clk);
        #2;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bit_x(input logic b, output logic s);
        tb_sda = b;
        t(4);
        scl = 1'b1;
        t(2);
        s = sda_w;
        t(2);
        scl = 1'b0;
    endtask
    task automatic xbyte(input logic [7:0] b, input logic rdn, output logic [7:0] r);
        logic a;
        for (int i = 7; i >= 0; i--) bit_x(b[i], r[i]);
        bit_x(1'b1, a);
        if (!rdn) check({7'h00, a}, 8'h00);
    endtask
    task automatic edge_x(input logic first);
        tb_sda = first;
        t(2);
        scl = 1'b1;
        t(4);
        tb_sda = ~first;
        t(4);
        scl = first ? 1'b0 : 1'b1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        edge_x(1'b1);
        xbyte({rxbb_pkg::DEV_ADDR, 1'b0}, 1'b0, rd);
        xbyte(a, 1'b0, rd);
        xbyte(d, 1'b0, rd);
        edge_x(1'b0);
        t(4);
    endtask
    task automatic conclude();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        {rst_b, preset} = 2'b00;
        {scl, tb_sda} = 2'b11;
        num_errors = 0;
        comparisons = 0;
        n = $urandom(13);
        raw = 8'($urandom() & 32'h0000007F);
        t(16);
        rst_b = 1'b1;
        t(2);
        check({ifs, chf, mods, tc}, 8'h04);
        check({5'h00, fsk}, 8'h00);
        wr(rxbb_pkg::OFS_IF_AND_FILTER_SELECT, 8'h13);
        check({3'h0, ifs, chf, mods}, 8'h13);
        // timing 3 and FSK setting 5 both reach the outputs in FSK.
        wr(rxbb_pkg::OFS_DEMODULATOR_CONFIG, 8'h2B);
        check({2'h0, tc, fsk}, 8'h1D);
        wr(rxbb_pkg::OFS_IF_AND_FILTER_SELECT, 8'h03);
        check({1'b0, mods, chf, fsk}, 8'h08);
        edge_x(1'b1);
        xbyte({rxbb_pkg::DEV_ADDR, 1'b0}, 1'b0, rd);
        xbyte(rxbb_pkg::OFS_SIGNAL_STRENGTH_VALUE, 1'b0, rd);
        edge_x(1'b1);
        xbyte({rxbb_pkg::DEV_ADDR, 1'b1}, 1'b0, rd);
        xbyte(8'hFF, 1'b1, rd);
        edge_x(1'b0);
        check(rd, raw);
        preset = 1'b1;
        for (n = 0; n < 48000 && good < 2; n++) t(1);
        // A missed frame counts as a mismatch and the run goes on to the report.
        if (good < 2) num_errors++;
        check(smp_v, raw);
        check(8'(bad), 8'h00);
        wr(rxbb_pkg::OFS_IF_AND_FILTER_SELECT, 8'h13);
        check({7'h00, mods}, 8'h01);
        preset = 1'b0;
        t(3);
        check({7'h00, pin}, 8'h01);
        // release 0x9 kept well below the attack level.
        wr(rxbb_pkg::OFS_GAIN_LOOP_CONFIG, 8'h26);
        mg = 1'b0;
        // both boundaries first, then random levels.
        for (int i = 0; i < 8; i++) begin
            raw = (i < 4) ? gr[i] : 8'($urandom());
            if (raw > rxbb_pkg::ATTACK_RST) begin
                mg = 1'b1;
            end else if (raw < 8'h90) begin
                mg = 1'b0;
            end
            t(4);
            check({7'h00, gl}, {7'h00, mg});
        end
        wr(rxbb_pkg::OFS_GAIN_LOOP_CONFIG, 8'h25);
        raw = 8'hFF;
        t(4);
        check({7'h00, gl}, 8'h00);
        conclude();
    end
endmodule
`default_nettype wire
